/* File: design/dac_cal_pkg.sv */
`default_nettype none
package dac_cal_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] CLKDIV_ADDR = 12'h0e7;
  localparam logic [11:0] PAGE_ADDR = 12'h0e8;
  localparam logic [11:0] CTRL_ADDR = 12'h0e9;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CLKDIV_RESET = 8'h30; // upper nibble 0x3, clock gate off
  localparam logic [3:0] PAGE_RESET = 4'hf;
  localparam logic CTRL_BIT_RESET = 1'b0;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CLKDIV_KEEP_LSB = 4; // upper nibble kept as written
  localparam int CLKDIV_GATE_BIT = 3;
  localparam int PAGE_CH0_BIT = 0;
  localparam int PAGE_CH1_BIT = 2;
  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_ACTIVE_BIT = 6;
  localparam int CTRL_SATHI_BIT = 5;
  localparam int CTRL_SATLO_BIT = 4;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_ENABLE_BIT = 0;
  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam int CAL_TICK_DIV = 4; // core cycles per calibration clock tick
  localparam int CAL_TICKS_PER_CYCLE = 16;
  localparam int CAL_CYCLES = 4;
  localparam int NUM_CHANNELS = 2;
  // engine states
  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_RUN = 1'b1
  } eng_state_t;
endpackage
`default_nettype wire

/* File: design/cal_channel_engine.sv */
`timescale 1ns/10ps
`default_nettype none
module cal_channel_engine #(
  parameter int TICKS = dac_cal_pkg::CAL_TICKS_PER_CYCLE,
  parameter int CYCLES = dac_cal_pkg::CAL_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic calTick,
  input wire logic startPulse,
  input wire logic satHigh,
  input wire logic satLow,
  // status
  output logic active,
  output logic done,
  output logic errHigh,
  output logic errLow,
  output logic timeout
);
  localparam int TW = (TICKS > 1) ? $clog2(TICKS) : 1;
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICKS - 1);
  localparam logic [CW-1:0] CYCLE_LAST = CW'(CYCLES - 1);

  // refuse counts that leave the sequence empty
  if (TICKS < 1 || CYCLES < 1) begin : g_bad_count
    $error("engine needs at least one tick and one cycle");
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  dac_cal_pkg::eng_state_t state_ff, nxt_state;
  logic [TW-1:0] tickCnt_ff, nxt_tickCnt;
  logic [CW-1:0] cycleCnt_ff, nxt_cycleCnt;
  logic curHi_ff, nxt_curHi, curLo_ff, nxt_curLo;
  logic nxt_active, nxt_done, nxt_errHigh, nxt_errLow, nxt_timeout;

  wire running = (state_ff == dac_cal_pkg::ENG_RUN) && calTick;
  wire cycleEnd = running && (tickCnt_ff == TICK_LAST);
  wire lastCycle = cycleEnd && (cycleCnt_ff == CYCLE_LAST);
  wire hiSeen = curHi_ff | satHigh;
  wire loSeen = curLo_ff | satLow;

  // next state; a start wins over a finish in the same cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_tickCnt = tickCnt_ff;
    nxt_cycleCnt = cycleCnt_ff;
    nxt_curHi = curHi_ff;
    nxt_curLo = curLo_ff;
    nxt_active = active;
    nxt_done = done;
    nxt_errHigh = errHigh;
    nxt_errLow = errLow;
    nxt_timeout = timeout;
    if (startPulse) begin
      nxt_state = dac_cal_pkg::ENG_RUN;
      nxt_tickCnt = '0;
      nxt_cycleCnt = '0;
      nxt_curHi = 1'b0;
      nxt_curLo = 1'b0;
      nxt_active = 1'b1;
      nxt_done = 1'b0;
      nxt_errHigh = 1'b0;
      nxt_errLow = 1'b0;
      nxt_timeout = 1'b0;
    end else if (running) begin
      nxt_curHi = hiSeen;
      nxt_curLo = loSeen;
      nxt_tickCnt = tickCnt_ff + 1'b1;
      if (cycleEnd) begin
        nxt_errHigh = errHigh | hiSeen;
        nxt_errLow = errLow | loSeen;
        nxt_curHi = 1'b0;
        nxt_curLo = 1'b0;
        nxt_tickCnt = '0;
        nxt_cycleCnt = cycleCnt_ff + 1'b1;
      end
      if (lastCycle) begin
        nxt_state = dac_cal_pkg::ENG_IDLE;
        nxt_active = 1'b0;
        nxt_done = 1'b1;
        nxt_timeout = errHigh | hiSeen | errLow | loSeen;
      end
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= dac_cal_pkg::ENG_IDLE;
      tickCnt_ff <= '0;
      cycleCnt_ff <= '0;
      curHi_ff <= 1'b0;
      curLo_ff <= 1'b0;
      active <= 1'b0;
      done <= 1'b0;
      errHigh <= 1'b0;
      errLow <= 1'b0;
      timeout <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tickCnt_ff <= nxt_tickCnt;
      cycleCnt_ff <= nxt_cycleCnt;
      curHi_ff <= nxt_curHi;
      curLo_ff <= nxt_curLo;
      active <= nxt_active;
      done <= nxt_done;
      errHigh <= nxt_errHigh;
      errLow <= nxt_errLow;
      timeout <= nxt_timeout;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_start_clears: assert property (@(posedge core_clk) disable iff (!nrst)
    startPulse |=> active && !done && !errHigh && !errLow && !timeout)
    else $error("start did not clear flags");
  a_done_ends_active: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(done) |-> $fell(active))
    else $error("finish and active not in same cycle");
  a_active_whole_run: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_ff == dac_cal_pkg::ENG_RUN) |-> active && !done)
    else $error("active low during run");
  a_timeout_flag: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(done) |-> (timeout == (errHigh || errLow)))
    else $error("timeout does not match saturation at finish");
  a_sat_cycle_end: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(errHigh) |-> $past(cycleEnd) && !$past(startPulse))
    else $error("high saturation flag set outside cycle end");
  a_satlo_cycle_end: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(errLow) |-> $past(cycleEnd))
    else $error("low saturation flag set outside cycle end");
  c_clean_finish: cover property (@(posedge core_clk) disable iff (!nrst)
    $rose(done) && !timeout);
  c_timeout_finish: cover property (@(posedge core_clk) disable iff (!nrst)
    $rose(done) && timeout);
endmodule
`default_nettype wire

/* File: design/dac_self_calibration_control.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Divider bit 3 runs the calibration clock when 1 and stops it when 0.
// - The page field bit 0 selects channel zero and bit 2 selects channel one.
// - Control writes land in every channel whose page bit is set.
// - Control bit 7 reads 1 once a sequence has completed for the paged channel.
// - A finish with any saturation flag set is reported as a timeout.
// - Control bit 6 reads 1 for the whole time a sequence runs.
// - Bit 5 is set at a cycle end when a sub-converter saturated high.
// - Bit 4 is set at a cycle end when a sub-converter saturated low.
// - A zero to one write of control bit 1 starts the paged channels.
// - Control bit 0 enables the sub-converters and coefficients only while 1.
// - Reserved page and control bits are read only and read as zero.
module dac_self_calibration_control #(
  parameter int TICK_DIV = dac_cal_pkg::CAL_TICK_DIV,
  parameter int TICKS = dac_cal_pkg::CAL_TICKS_PER_CYCLE,
  parameter int CYCLES = dac_cal_pkg::CAL_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData_ff,
  output logic regRdValid_ff,
  // saturation pins from the calibration sub-converters, per channel
  input wire logic [1:0] satHighPin,
  input wire logic [1:0] satLowPin,
  // calibration outputs
  output logic calClkRun_ff,
  output logic [1:0] dacCalEnable_ff,
  output logic [1:0] coefApply_ff,
  output logic [1:0] calActive,
  output logic [1:0] calDone,
  output logic [1:0] calTimeout
);
  localparam int NCH = dac_cal_pkg::NUM_CHANNELS;
  localparam int DW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_DIV - 1);

  // refuse a divider that would never tick
  if (TICK_DIV < 1) begin : g_bad_div
    $error("tick divider must be at least one");
  end

  // page bit of a channel: bit 0 for channel zero, bit 2 for channel one
  function automatic logic pageHit(input logic [3:0] page, input int ch);
    pageHit = (ch == 0) ? page[dac_cal_pkg::PAGE_CH0_BIT] : page[dac_cal_pkg::PAGE_CH1_BIT];
  endfunction

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire clkdivHit = (regAddr == dac_cal_pkg::CLKDIV_ADDR);
  wire pageAddrHit = (regAddr == dac_cal_pkg::PAGE_ADDR);
  wire ctrlHit = (regAddr == dac_cal_pkg::CTRL_ADDR);
  wire clkdivWr = regWr && clkdivHit;
  wire pageWr = regWr && pageAddrHit;
  wire ctrlWr = regWr && ctrlHit;

  // ---------------------------------------------------------------
  // divider and page registers
  // ---------------------------------------------------------------
  logic [3:0] divKeep_ff;
  logic [3:0] page_ff;

  // upper nibble stored as written; gate bit drives the tick divider
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      divKeep_ff <= dac_cal_pkg::CLKDIV_RESET[7:4];
      calClkRun_ff <= dac_cal_pkg::CLKDIV_RESET[dac_cal_pkg::CLKDIV_GATE_BIT];
    end else if (clkdivWr) begin
      divKeep_ff <= regWrData[7:4];
      calClkRun_ff <= regWrData[dac_cal_pkg::CLKDIV_GATE_BIT];
    end
  end

  // channel page field
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      page_ff <= dac_cal_pkg::PAGE_RESET;
    end else if (pageWr) begin
      page_ff <= regWrData[3:0];
    end
  end

  // ---------------------------------------------------------------
  // calibration clock as an enable pulse
  // ---------------------------------------------------------------
  logic [DW-1:0] divCnt_ff;
  logic calTick_ff;
  wire divWrap = (divCnt_ff == DIV_LAST);
  wire [DW-1:0] nxt_divCnt = divWrap ? '0 : divCnt_ff + 1'b1;

  // ticks only while the gate bit is set
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt_ff <= '0;
      calTick_ff <= 1'b0;
    end else begin
      divCnt_ff <= calClkRun_ff ? nxt_divCnt : '0;
      calTick_ff <= calClkRun_ff && divWrap;
    end
  end

  // ---------------------------------------------------------------
  // saturation pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] satMeta_ff, satSync_ff;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      satMeta_ff <= 4'h0;
      satSync_ff <= 4'h0;
    end else begin
      satMeta_ff <= {satLowPin, satHighPin};
      satSync_ff <= satMeta_ff;
    end
  end

  // ---------------------------------------------------------------
  // per channel control bits and engines
  // ---------------------------------------------------------------
  logic [NCH-1:0] startBit_ff;
  logic [NCH-1:0] startPulse;
  logic [NCH-1:0] chHit;
  logic [NCH-1:0] errHigh, errLow;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      // write lands in every paged channel
      assign chHit[ch] = pageHit(page_ff, ch);
      wire chWr = ctrlWr && chHit[ch];
      // rising edge of the start bit
      assign startPulse[ch] = chWr && regWrData[dac_cal_pkg::CTRL_START_BIT] && !startBit_ff[ch];

      // stored enable and start bits
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          startBit_ff[ch] <= dac_cal_pkg::CTRL_BIT_RESET;
          dacCalEnable_ff[ch] <= dac_cal_pkg::CTRL_BIT_RESET;
        end else if (chWr) begin
          startBit_ff[ch] <= regWrData[dac_cal_pkg::CTRL_START_BIT];
          dacCalEnable_ff[ch] <= regWrData[dac_cal_pkg::CTRL_ENABLE_BIT];
        end
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          coefApply_ff[ch] <= 1'b0;
        end else begin
          coefApply_ff[ch] <= dacCalEnable_ff[ch] && calDone[ch] && !calTimeout[ch];
        end
      end

      cal_channel_engine #(
        .TICKS(TICKS),
        .CYCLES(CYCLES)
      ) u_engine (
        .core_clk(core_clk),
        .nrst(nrst),
        .calTick(calTick_ff),
        .startPulse(startPulse[ch]),
        .satHigh(satSync_ff[ch]),
        .satLow(satSync_ff[NCH + ch]),
        .active(calActive[ch]),
        .done(calDone[ch]),
        .errHigh(errHigh[ch]),
        .errLow(errLow[ch]),
        .timeout(calTimeout[ch])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // readback
  // ---------------------------------------------------------------
  // channel zero when its page bit is set, else channel one when paged
  wire rdCh = !chHit[0];
  wire rdAny = chHit[0] || chHit[1];
  // status byte with reserved bits zero
  wire [7:0] ctrlByte = rdAny ? {calDone[rdCh], calActive[rdCh], errHigh[rdCh], errLow[rdCh],
                                 2'b00, startBit_ff[rdCh], dacCalEnable_ff[rdCh]} : 8'h00;
  wire [7:0] divByte = {divKeep_ff, calClkRun_ff, 3'b000};
  wire [7:0] pageByte = {4'h0, page_ff};
  wire [7:0] rdMux = clkdivHit ? divByte :
                     pageAddrHit ? pageByte :
                     ctrlHit ? ctrlByte : 8'h00;

  // read data is registered one cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData_ff <= 8'h00;
      regRdValid_ff <= 1'b0;
    end else begin
      regRdValid_ff <= regRd;
      if (regRd) begin
        regRdData_ff <= rdMux;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_clk_gate_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !calClkRun_ff |=> !calTick_ff)
    else $error("calibration tick while clock gated off");
  a_start_paged: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrlWr && regWrData[1] && page_ff[2] && !startBit_ff[1]) |=> calActive[1])
    else $error("paged channel one did not start");
  a_start_unpaged: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrlWr && !page_ff[0] && !calActive[0]) |=> !calActive[0])
    else $error("unpaged channel zero started");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    (regRd && pageAddrHit) |=> regRdData_ff[7:4] == 4'h0)
    else $error("reserved page bits not zero");
  a_ctrl_resv: assert property (@(posedge core_clk) disable iff (!nrst)
    (regRd && ctrlHit) |=> regRdData_ff[3:2] == 2'b00 && regRdValid_ff)
    else $error("reserved control bits not zero");
  a_enable_write: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrlWr && page_ff[0]) |=> dacCalEnable_ff[0] == $past(regWrData[0]))
    else $error("enable bit not stored for paged channel");
  a_apply_needs_en: assert property (@(posedge core_clk) disable iff (!nrst)
    coefApply_ff[0] |-> $past(dacCalEnable_ff[0]))
    else $error("coefficients applied with enable low");
  c_both_running: cover property (@(posedge core_clk) disable iff (!nrst)
    calActive[0] && calActive[1]);
  c_ch1_done: cover property (@(posedge core_clk) disable iff (!nrst)
    $rose(calDone[1]));
  c_read_status: cover property (@(posedge core_clk) disable iff (!nrst)
    regRd && ctrlHit && calDone[0]);
endmodule
`default_nettype wire

/* File: bench/dac_self_calibration_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dac_self_calibration_control_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk;
  logic nrst;
  logic regWr;
  logic regRd;
  logic [11:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData_ff;
  logic regRdValid_ff;
  logic [1:0] satHighPin;
  logic [1:0] satLowPin;
  logic calClkRun_ff;
  logic [1:0] dacCalEnable_ff;
  logic [1:0] coefApply_ff;
  logic [1:0] calActive;
  logic [1:0] calDone;
  logic [1:0] calTimeout;
  logic [7:0] rndPage;
  int errors;
  int total_checks;
  int cycleCount;
  localparam int CEILING = 20000;

  // short counts keep each sequence at four ticks of one core cycle
  dac_self_calibration_control #(.TICK_DIV(1), .TICKS(2), .CYCLES(2)) i_dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .regWr(regWr),
    .regRd(regRd),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData_ff(regRdData_ff),
    .regRdValid_ff(regRdValid_ff),
    .satHighPin(satHighPin),
    .satLowPin(satLowPin),
    .calClkRun_ff(calClkRun_ff),
    .dacCalEnable_ff(dacCalEnable_ff),
    .coefApply_ff(coefApply_ff),
    .calActive(calActive),
    .calDone(calDone),
    .calTimeout(calTimeout)
  );

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // cut a hang short after the ceiling
  always @(posedge core_clk) begin
    cycleCount++;
    if (cycleCount == CEILING) begin
      errors++;
      $display("MISMATCH at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, driven at the falling edge
  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regWr = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge core_clk);
    regWr = 1'b0;
  endtask

  // read data and valid stand one cycle after the strobe edge
  task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regRd = 1'b1;
    regAddr = a;
    @(negedge core_clk);
    regRd = 1'b0;
    check({7'h00, regRdValid_ff}, 8'h01);
    d = regRdData_ff;
  endtask

  task automatic expect_read(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_read(a, v);
    check(v, exp);
  endtask

  task automatic wait_done(input logic [1:0] m);
    int n;
    n = 0;
    while ((calDone & m) !== m && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    check({6'h00, calDone & m}, {6'h00, m});
  endtask

  // finished status with start and enable still stored
  function automatic logic [7:0] ctrl_exp(input logic hi, input logic lo, input logic en);
    return {2'b10, hi, lo, 2'b00, 1'b1, en};
  endfunction

  // one full sequence on the paged channels, then per-channel readback
  task automatic run_cal(input logic [7:0] page, input logic en, input logic [1:0] hi,
                         input logic [1:0] lo);
    logic [1:0] m;
    logic [1:0] sat;
    logic [7:0] v;
    m = {page[2], page[0]};
    sat = m & (hi | lo);
    reg_write(dac_cal_pkg::PAGE_ADDR, page);
    reg_write(dac_cal_pkg::CTRL_ADDR, {7'h00, en});
    satHighPin = hi;
    satLowPin = lo;
    repeat (3) @(negedge core_clk);
    reg_write(12'h0ed, 8'ha2);
    reg_write(dac_cal_pkg::CTRL_ADDR, {6'h00, 1'b1, en});
    @(negedge core_clk);
    check({6'h00, calActive & m}, {6'h00, m});
    check({6'h00, calDone & m}, 8'h00);
    check({6'h00, dacCalEnable_ff & m}, {6'h00, en ? m : 2'b00});
    wait_done(m);
    check({6'h00, calActive & m}, 8'h00);
    check({6'h00, calTimeout & m}, {6'h00, sat});
    repeat (2) @(negedge core_clk);
    check({6'h00, coefApply_ff & m}, {6'h00, en ? m & ~sat : 2'b00});
    for (int c = 0; c < 2; c++) begin
      if (m[c]) begin
        reg_write(dac_cal_pkg::PAGE_ADDR, c == 1 ? 8'h04 : 8'h01);
        reg_read(dac_cal_pkg::CTRL_ADDR, v);
        check(v, ctrl_exp(hi[c], lo[c], en));
      end
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 12'h000;
    regWrData = 8'h00;
    satHighPin = 2'b00;
    satLowPin = 2'b00;
    errors = 0;
    total_checks = 0;
    cycleCount = 0;
    void'($urandom(32'h7e13));
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    // register defaults, unmapped place, reserved bits
    expect_read(dac_cal_pkg::CLKDIV_ADDR, 8'h30);
    expect_read(dac_cal_pkg::PAGE_ADDR, 8'h0f);
    expect_read(dac_cal_pkg::CTRL_ADDR, 8'h00);
    expect_read(12'h0ea, 8'h00);
    reg_write(dac_cal_pkg::PAGE_ADDR, 8'hff);
    expect_read(dac_cal_pkg::PAGE_ADDR, 8'h0f);
    reg_write(dac_cal_pkg::PAGE_ADDR, 8'h01);
    reg_write(dac_cal_pkg::CTRL_ADDR, 8'hfc);
    expect_read(dac_cal_pkg::CTRL_ADDR, 8'h00);
    // calibration clock gate on
    reg_write(dac_cal_pkg::CLKDIV_ADDR, 8'h3f);
    expect_read(dac_cal_pkg::CLKDIV_ADDR, 8'h38);
    check({7'h00, calClkRun_ff}, 8'h01);
    // both channels at once, then each saturation side
    run_cal(8'h05, 1'b1, 2'b00, 2'b00);
    run_cal(8'h04, 1'b1, 2'b10, 2'b00);
    run_cal(8'h01, 1'b1, 2'b00, 2'b01);
    run_cal(8'h01, 1'b0, 2'b00, 2'b00);
    // start bit held at 1 gives no new start
    reg_write(dac_cal_pkg::CTRL_ADDR, 8'h02);
    repeat (2) @(negedge core_clk);
    check({6'h00, calDone}, 8'h03);
    // sequence stalls while the calibration clock is stopped
    reg_write(dac_cal_pkg::CLKDIV_ADDR, 8'h30);
    check({7'h00, calClkRun_ff}, 8'h00);
    reg_write(dac_cal_pkg::CTRL_ADDR, 8'h01);
    reg_write(12'h0ed, 8'ha2);
    reg_write(dac_cal_pkg::CTRL_ADDR, 8'h03);
    repeat (20) @(negedge core_clk);
    check({6'h00, calActive & 2'b01}, 8'h01);
    check({6'h00, calDone & 2'b01}, 8'h00);
    reg_write(dac_cal_pkg::CLKDIV_ADDR, 8'h38);
    wait_done(2'b01);
    // random pages, enables and saturation pins
    for (int i = 0; i < 8; i++) begin
      rndPage = ($urandom % 3 == 0) ? 8'h05 : (($urandom % 2 == 0) ? 8'h01 : 8'h04);
      run_cal(rndPage, 1'($urandom), 2'($urandom), 2'($urandom));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
